// *** inc/dcp_pkg.sv ***
// constants and types of the clock-enable power-state control block
// How it works
// RULE1: controller waits mode-register timings before lowering enable
// RULE2: sample enable each edge, keep previous level
// RULE3: decide from state held before edge
// RULE4: enable low twice keeps power state
// RULE5: power-down transitions accept only nop or deselect
// RULE6: self refresh exit accepts only nop
// RULE7: refresh with falling enable, idle, enters self refresh
// RULE8: falling enable, open bank: active power-down
// RULE9: falling enable, idle or refreshing: precharge power-down
// RULE10: entry during busy op resolves after completion
// RULE11: controller holds enable level for minimum time
// RULE12: controller issues nop during self refresh exit time
// RULE13: no internal refresh while in power-down
// RULE14: termination never steers states, off in self refresh
// RULE15: command pins ignored in low-power states
// RULE16: controller waits 512 clocks before first write; the bench model writes after eight nops and four other commands
// RULE17: idle only when closed, quiet, enable high
// RULE18: controller never drives unlisted combinations
// RULE19: self refresh exit starts without a clock edge
// RULE20: deselect equals nop, never ends a burst
// RULE21: controller tracks bank status for power-down flavour
package dcp_pkg;

	// ==========================================================
	// power states of the link side
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ACTIVE = 3'b001,
		ST_APD = 3'b010,
		ST_PPD = 3'b011,
		ST_SREF = 3'b100,
		ST_PD_PEND = 3'b101
	} dcp_state_t;

	// ==========================================================
	// decoded commands, deselect folds into nop
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_MRS = 4'h1,
		CMD_REF = 4'h2,
		CMD_PRE = 4'h3,
		CMD_ACT = 4'h4,
		CMD_WR = 4'h5,
		CMD_RD = 4'h6,
		CMD_ZQ = 4'h7
	} dcp_cmd_t;

	// ==========================================================
	// reset values
	localparam dcp_state_t STATE_RST = ST_IDLE;
	localparam dcp_cmd_t CMD_RST = CMD_NOP;
	localparam logic CKE_RST = 1'b0;
	localparam int SYNC_STAGES = 2;

endpackage

// *** inc/dcp_cmd_if.sv ***
// command pins and decoded command between the top and its decoder
interface dcp_cmd_if;
	import dcp_pkg::*;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	dcp_cmd_t cmd;
	modport decoder (
		input cs_n,
		input ras_n,
		input cas_n,
		input we_n,
		output cmd
	);
	modport user (
		output cs_n,
		output ras_n,
		output cas_n,
		output we_n,
		input cmd
	);
endinterface

// *** hw/dcp_sync.sv ***
// two-flop level synchroniser for a vector of independent levels
module dcp_sync
	import dcp_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ==========================================================
	// stages
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// only the second flop is visible outside
	always_comb begin
		next_meta = nrst ? d : '0;
		next_q = nrst ? meta : '0;
	end

	always_ff @(posedge clk) begin
		meta <= next_meta;
		q <= next_q;
	end
endmodule

// *** hw/dcp_cmd_decode.sv ***
// decoder of the four command pins into a command code
module dcp_cmd_decode
	import dcp_pkg::*;
(
	dcp_cmd_if.decoder cif
);
	// ==========================================================
	// decode, deselect reads as nop
	always_comb begin
		cif.cmd = CMD_NOP;
		if (!cif.cs_n) begin
			unique case ({cif.ras_n, cif.cas_n, cif.we_n})
				3'b000: cif.cmd = CMD_MRS;
				3'b001: cif.cmd = CMD_REF;
				3'b010: cif.cmd = CMD_PRE;
				3'b011: cif.cmd = CMD_ACT;
				3'b100: cif.cmd = CMD_WR;
				3'b101: cif.cmd = CMD_RD;
				3'b110: cif.cmd = CMD_ZQ;
				3'b111: cif.cmd = CMD_NOP;
			endcase
		end
	end
endmodule

// *** hw/dcp_power_ctrl.sv ***
// clock-enable power-state control with core and link clock domains
module dcp_power_ctrl
	import dcp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic odt,
	input wire logic banks_open,
	input wire logic reading,
	input wire logic writing,
	input wire logic precharging,
	input wire logic refreshing,
	input wire logic timers_busy,
	input wire logic refresh_req,
	output logic odt_active,
	output logic sr_wake,
	output logic in_apd,
	output logic in_ppd,
	output logic in_sref,
	output logic dev_idle,
	output logic refresh_go,
	output logic cmd_strobe,
	output dcp_cmd_t cmd_code
);
	// ==========================================================
	// link-side reset, nrst carried onto ck
	logic rst_meta;
	logic link_nrst;

	// plain two-stage capture; only link_nrst is read
	always_ff @(posedge ck) begin
		rst_meta <= nrst;
		link_nrst <= rst_meta;
	end

	// ==========================================================
	// core status carried onto ck
	logic [5:0] core_l;
	logic banks_l;
	logic busy_l;
	logic refr_l;
	logic tmr_l;
	logic core_quiet;

	dcp_sync #(.W(6)) u_core_sync (
		.clk(ck),
		.nrst(link_nrst),
		.d({banks_open, reading, writing, precharging, refreshing, timers_busy}),
		.q(core_l)
	);

	// busy covers the ops that defer the power-down flavour
	assign banks_l = core_l[5];
	assign busy_l = core_l[4] | core_l[3] | core_l[2];
	assign refr_l = core_l[1];
	assign tmr_l = core_l[0];
	assign core_quiet = !banks_l && !busy_l && !refr_l && !tmr_l;

	// ==========================================================
	// command decode
	dcp_cmd_if cif ();
	dcp_cmd_t cmd;

	assign cif.cs_n = cs_n;
	assign cif.ras_n = ras_n;
	assign cif.cas_n = cas_n;
	assign cif.we_n = we_n;
	assign cmd = cif.cmd;

	dcp_cmd_decode u_dec (
		.cif(cif.decoder)
	);

	// ==========================================================
	// power state machine on the link clock
	dcp_state_t state;
	dcp_state_t next_state;
	logic cke_prev;
	logic next_cke_prev;
	logic odt_q;
	logic next_odt_q;
	logic idle_l;
	logic next_idle_l;
	logic evt_tgl;
	logic next_evt_tgl;
	dcp_cmd_t evt_code;
	dcp_cmd_t next_evt_code;
	logic is_nop;
	logic in_pd;

	assign is_nop = (cmd == CMD_NOP); // RULE20
	assign in_pd = (state == ST_APD) || (state == ST_PPD) || (state == ST_PD_PEND);

	// decisions use the registered state and previous enable level
	always_comb begin
		next_state = state; // RULE3
		next_cke_prev = cke; // RULE2
		next_odt_q = odt;
		next_evt_tgl = evt_tgl;
		next_evt_code = evt_code;
		unique case ({cke_prev, cke})
			2'b00: begin
				// command pins are don't care here
				if (state == ST_PD_PEND && !busy_l) begin // RULE10
					next_state = banks_l ? ST_APD : ST_PPD;
				end
			end
			2'b01: begin
				if (is_nop) begin // RULE5 RULE6
					if (state == ST_SREF) begin
						next_state = ST_IDLE;
					end else if (in_pd) begin
						next_state = banks_l ? ST_ACTIVE : ST_IDLE;
					end
				end
			end
			2'b10: begin
				if (is_nop) begin // RULE5
					if (refr_l) begin // RULE9
						next_state = ST_PPD;
					end else if (busy_l) begin // RULE10
						next_state = ST_PD_PEND;
					end else if (banks_l) begin // RULE8
						next_state = ST_APD;
					end else begin // RULE9
						next_state = ST_PPD;
					end
				end else if (cmd == CMD_REF && state == ST_IDLE && core_quiet) begin // RULE7
					next_state = ST_SREF;
				end
			end
			2'b11: begin
				// normal operation tracks the banks
				next_state = banks_l ? ST_ACTIVE : ST_IDLE;
				if (!is_nop) begin
					next_evt_tgl = !evt_tgl;
					next_evt_code = cmd;
				end
			end
		endcase
		// termination input only feeds next_odt_q above, never the state decisions
		next_idle_l = (next_state == ST_IDLE) && cke && core_quiet; // RULE17
	end

	always_ff @(posedge ck) begin
		if (!link_nrst) begin
			state <= STATE_RST;
			cke_prev <= CKE_RST;
			odt_q <= 1'b0;
			idle_l <= 1'b0;
			evt_tgl <= 1'b0;
			evt_code <= CMD_RST;
		end else begin
			state <= next_state;
			cke_prev <= next_cke_prev;
			odt_q <= next_odt_q;
			idle_l <= next_idle_l;
			evt_tgl <= next_evt_tgl;
			evt_code <= next_evt_code;
		end
	end

	// ==========================================================
	// link-side outputs
	// termination off in self refresh, wake needs no edge
	assign odt_active = odt_q && (state != ST_SREF); // RULE14
	assign sr_wake = (state == ST_SREF) && cke; // RULE19

	// ==========================================================
	// state levels and command event carried onto clk
	logic [4:0] lvl_s;
	logic evt_s;
	logic evt_d;
	logic next_evt_d;
	logic next_cmd_strobe;
	dcp_cmd_t next_cmd_code;

	dcp_sync #(.W(5)) u_lvl_sync (
		.clk(clk),
		.nrst(nrst),
		.d({state == ST_APD, state == ST_PPD || state == ST_PD_PEND,
			state == ST_SREF, idle_l, evt_tgl}),
		.q(lvl_s)
	);

	assign in_apd = lvl_s[4];
	assign in_ppd = lvl_s[3];
	assign in_sref = lvl_s[2];
	assign dev_idle = lvl_s[1];
	assign evt_s = lvl_s[0];

	// code is held a full link period, so it is steady when sampled
	always_comb begin
		next_evt_d = evt_s;
		next_cmd_strobe = evt_s ^ evt_d;
		next_cmd_code = (evt_s ^ evt_d) ? evt_code : cmd_code;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			evt_d <= 1'b0;
			cmd_strobe <= 1'b0;
			cmd_code <= CMD_RST;
		end else begin
			evt_d <= next_evt_d;
			cmd_strobe <= next_cmd_strobe;
			cmd_code <= next_cmd_code;
		end
	end

	// internal refresh held off during power-down
	assign refresh_go = refresh_req && !in_apd && !in_ppd; // RULE13

	// ==========================================================
	// checks on the link clock
	AST_PREV_EDGE: assert property (@(posedge ck) disable iff (!link_nrst) // RULE2
		$past(link_nrst) |-> cke_prev == $past(cke))
		else $error("previous enable level not kept");

	AST_HOLD_SREF: assert property (@(posedge ck) disable iff (!link_nrst) // RULE4
		(state == ST_SREF && !cke_prev && !cke) |=> state == ST_SREF)
		else $error("self refresh left with enable low");

	AST_HOLD_PD: assert property (@(posedge ck) disable iff (!link_nrst) // RULE15
		((state == ST_APD || state == ST_PPD) && !cke_prev && !cke)
		|=> state == $past(state))
		else $error("power-down changed with enable low");

	AST_BAD_CMD: assert property (@(posedge ck) disable iff (!link_nrst) // RULE5
		(cke_prev != cke && !is_nop && cmd != CMD_REF) |=> state == $past(state))
		else $error("transition taken on a non-nop command");

	AST_SRX: assert property (@(posedge ck) disable iff (!link_nrst) // RULE6
		(state == ST_SREF && !cke_prev && cke && is_nop) |=> state == ST_IDLE)
		else $error("self refresh exit missed");

	AST_SRE: assert property (@(posedge ck) disable iff (!link_nrst) // RULE7
		(cke_prev && !cke && cmd == CMD_REF && state == ST_IDLE && core_quiet)
		|=> state == ST_SREF)
		else $error("self refresh entry missed");

	// the converse: no other path may land in self refresh
	AST_SRE_ONLY: assert property (@(posedge ck) disable iff (!link_nrst) // RULE7
		(state != ST_SREF) ##1 (state == ST_SREF)
		|-> $past(cmd) == CMD_REF && $past(cke_prev) && !$past(cke) && $past(core_quiet))
		else $error("self refresh entered without a legal request");

	AST_APD: assert property (@(posedge ck) disable iff (!link_nrst) // RULE8
		(cke_prev && !cke && is_nop && banks_l && !busy_l && !refr_l)
		|=> state == ST_APD)
		else $error("active power-down not entered");

	AST_PPD: assert property (@(posedge ck) disable iff (!link_nrst) // RULE9
		(cke_prev && !cke && is_nop && (refr_l || (!banks_l && !busy_l)))
		|=> state == ST_PPD)
		else $error("precharge power-down not entered");

	AST_PEND: assert property (@(posedge ck) disable iff (!link_nrst) // RULE10
		(state == ST_PD_PEND && !busy_l && !cke_prev && !cke)
		|=> state == ($past(banks_l) ? ST_APD : ST_PPD))
		else $error("deferred power-down flavour wrong");

	AST_IDLE: assert property (@(posedge ck) disable iff (!link_nrst) // RULE17
		idle_l |-> (state == ST_IDLE && cke_prev && $past(core_quiet)))
		else $error("idle flagged while not idle");

	AST_WAKE: assert property (@(posedge ck) disable iff (!link_nrst) // RULE19
		(state == ST_SREF && cke) |-> sr_wake)
		else $error("self refresh wake not raised");

	AST_NOP_EVT: assert property (@(posedge ck) disable iff (!link_nrst) // RULE20
		(cke_prev && cke && is_nop) |=> evt_tgl == $past(evt_tgl))
		else $error("nop posted as a command");

	// deferred power-down exits like the plain flavours
	AST_PDX: assert property (@(posedge ck) disable iff (!link_nrst) // RULE5
		(in_pd && !cke_prev && cke && is_nop)
		|=> state == ($past(banks_l) ? ST_ACTIVE : ST_IDLE))
		else $error("power-down exit went astray");

	AST_PD_DEAF: assert property (@(posedge ck) disable iff (!link_nrst) // RULE15
		(!cke_prev && !cke) |=> evt_tgl == $past(evt_tgl))
		else $error("command taken with enable low");

	AST_IDLE_SET: assert property (@(posedge ck) disable iff (!link_nrst) // RULE17
		(cke_prev && cke && core_quiet) |=> idle_l)
		else $error("idle not flagged while quiet");

	// ==========================================================
	// checks on the core clock
	AST_NO_REFRESH: assert property (@(posedge clk) disable iff (!nrst) // RULE13
		(in_apd || in_ppd) |-> !refresh_go)
		else $error("refresh issued in power-down");

	AST_STROBE_ONE: assert property (@(posedge clk) disable iff (!nrst)
		cmd_strobe |=> !cmd_strobe)
		else $error("command strobe longer than one cycle");

	AST_STROBE_CODE: assert property (@(posedge clk) disable iff (!nrst) // RULE20
		cmd_strobe |-> cmd_code != CMD_NOP)
		else $error("nop reported as a command");

endmodule

// *** bench/dcp_ctrl_model.sv ***
// memory controller model: link clock, clock-enable and command pins
module dcp_ctrl_model #(
	parameter int CKE_MIN = 3,
	parameter int XS_CYC = 4
) (
	output logic ck,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic odt
);
	timeunit 1ns;
	timeprecision 100ps;
	int held = 0;

	// ==========
	// memory clock runs free, also through power-down
	initial {ck, cke, cs_n, ras_n, cas_n, we_n, odt} = 7'h3E;
	always #16 ck = ~ck;
	always @(posedge ck) held <= held + 1;

	// ==========
	// one command per edge, changed 1 ns after the edge
	task put(input logic c, input logic [3:0] p, input logic o = 1'b0);
		@(posedge ck);
		#1;
		// enable level held a minimum time before it may move again
		while (c !== cke && held < CKE_MIN) begin
			{cs_n, ras_n, cas_n, we_n} = 4'hF;
			@(posedge ck);
			#1;
		end
		if (c !== cke) held = 0;
		cke = c;
		odt = o;
		cs_n = p[3];
		// unselected pins toggle, so a stale level never looks valid
		{ras_n, cas_n, we_n} = p[3] ? ~{ras_n, cas_n, we_n} : p[2:0];
	endtask

	// only nops during the self refresh exit time
	task sr_nops;
		repeat (XS_CYC) put(1'b1, 4'h7);
	endtask
endmodule

// *** bench/dcp_power_ctrl_bench.sv ***
// self-checking bench of the clock-enable power-state block
module dcp_power_ctrl_bench
	import dcp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] P_NOP = 4'h7;
	localparam logic [3:0] P_DES = 4'h8;
	localparam logic [3:0] P_REF = 4'h1;
	localparam logic [3:0] P_ACT = 4'h3;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [6:0] core_in = 7'h00;
	logic ck, cke, cs_n, ras_n, cas_n, we_n, odt;
	logic banks_open, reading, writing, precharging, refreshing, timers_busy, refresh_req;
	logic odt_active, sr_wake, in_apd, in_ppd, in_sref, dev_idle, refresh_go, cmd_strobe;
	dcp_cmd_t cmd_code;
	int failures = 0;
	int n_checks = 0;
	int k;

	// ==========
	always #2.5 clk = ~clk;
	assign {banks_open, reading, writing, precharging, refreshing, timers_busy,
		refresh_req} = core_in;
	dcp_ctrl_model u_ctrl (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .odt(odt));
	dcp_power_ctrl uut (.clk(clk), .nrst(nrst), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .odt(odt), .banks_open(banks_open), .reading(reading),
		.writing(writing), .precharging(precharging), .refreshing(refreshing),
		.timers_busy(timers_busy), .refresh_req(refresh_req), .odt_active(odt_active),
		.sr_wake(sr_wake), .in_apd(in_apd), .in_ppd(in_ppd), .in_sref(in_sref),
		.dev_idle(dev_idle), .refresh_go(refresh_go), .cmd_strobe(cmd_strobe),
		.cmd_code(cmd_code));

	// ==========
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// core levels change, then four link edges so the sync has settled
	task core(input logic [6:0] v);
		@(negedge clk);
		core_in = v;
		repeat (4) u_ctrl.put(cke, P_NOP);
	endtask

	// wait bounded for {apd, ppd, sref, idle}
	task pm(input logic [3:0] exp);
		int i;
		for (i = 0; i < 40 && {in_apd, in_ppd, in_sref, dev_idle} !== exp; i++) @(negedge clk);
		check("power state", {4'h0, in_apd, in_ppd, in_sref, dev_idle}, {4'h0, exp});
	endtask

	task sw;
		int i;
		for (i = 0; i < 16 && cmd_strobe !== 1'b1; i++) @(negedge clk);
	endtask

	task cmd(input logic [3:0] p, input dcp_cmd_t exp, input logic st);
		u_ctrl.put(1'b1, p);
		u_ctrl.put(1'b1, P_NOP);
		sw;
		check("cmd_strobe", {7'h0, cmd_strobe}, {7'h0, st});
		if (st) check("cmd_code", {4'h0, cmd_code}, {4'h0, exp});
	endtask

	// ==========
	task t_cmds;
		dcp_cmd_t codes[7];
		codes = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ};
		for (k = 0; k < 7; k++) cmd(k[3:0], codes[k], 1'b1);
		cmd(P_NOP, CMD_NOP, 1'b0);
		cmd(P_DES, CMD_NOP, 1'b0);
		pm(4'b0001);
		core(7'h02);
		pm(4'b0000);
		core(7'h00);
	endtask

	task t_sref;
		u_ctrl.put(1'b0, P_REF);
		pm(4'b0010);
		u_ctrl.put(1'b0, P_DES, 1'b1);
		u_ctrl.put(1'b0, P_DES, 1'b1);
		check("odt_active", {7'h0, odt_active}, 8'h00);
		check("sr_wake", {7'h0, sr_wake}, 8'h00);
		u_ctrl.put(1'b1, P_NOP, 1'b1);
		// the wake level follows the pin in the same step, so let it settle
		#1;
		check("sr_wake", {7'h0, sr_wake}, 8'h01);
		u_ctrl.sr_nops;
		pm(4'b0001);
		u_ctrl.put(1'b1, P_NOP, 1'b1);
		u_ctrl.put(1'b1, P_NOP, 1'b1);
		check("odt_active", {7'h0, odt_active}, 8'h01);
		u_ctrl.put(1'b1, P_NOP);
	endtask

	// entry, commands while low, refresh held off, exit
	task t_pd(input logic [6:0] v, input logic [3:0] exp, input logic [3:0] back);
		core(v);
		u_ctrl.put(1'b0, P_NOP);
		pm(exp);
		u_ctrl.put(1'b0, P_ACT);
		u_ctrl.put(1'b0, P_DES);
		sw;
		check("strobe in power-down", {7'h0, cmd_strobe}, 8'h00);
		check("refresh_go", {7'h0, refresh_go}, 8'h00);
		u_ctrl.put(1'b1, P_NOP);
		pm(back);
		check("refresh_go out", {7'h0, refresh_go}, {7'h0, v[0]});
		core(7'h00);
	endtask

	task t_defer(input logic [6:0] v);
		core(v);
		u_ctrl.put(1'b0, P_NOP);
		pm(4'b0100);
		core(7'h40);
		pm(4'b1000);
		u_ctrl.put(1'b1, P_NOP);
		pm(4'b0000);
		core(7'h00);
	endtask

	// controller deliberately wrong here: a command on the falling enable
	task t_refuse(input logic [3:0] p);
		core(7'h40);
		u_ctrl.put(1'b0, p);
		repeat (4) u_ctrl.put(1'b0, P_DES);
		check("refused entry", {4'h0, in_apd, in_ppd, in_sref, dev_idle}, 8'h00);
		u_ctrl.put(1'b1, P_NOP);
		core(7'h00);
	endtask

	// ==========
	// reset spans thirty core cycles, longer than four link edges
	initial begin
		repeat (30) @(negedge clk);
		nrst = 1'b1;
		repeat (4) u_ctrl.put(1'b1, P_NOP);
		t_cmds;
		t_sref;
		t_pd(7'h41, 4'b1000, 4'b0000);
		t_pd(7'h01, 4'b0100, 4'b0001);
		t_pd(7'h45, 4'b0100, 4'b0000);
		for (k = 0; k < 3; k++) t_defer(7'h20 >> k);
		t_refuse(P_ACT);
		t_refuse(P_REF);
		report_and_stop;
	end

	// watchdog well beyond the expected run of some six microseconds
	initial begin
		#60us;
		failures++;
		report_and_stop;
	end
endmodule
